/* File: core/vard_pkg.sv */
// constants shared by the virtual address region decoder
// assumes one 25 MHz clock and a plain strobe register port
package vard_pkg;
	localparam int ADDR_W = 32;            // virtual address width
	localparam int PHYS_W = 29;            // physical address width
	localparam int ASID_W = 8;             // address space identifier width
	localparam int REG_AW = 8;             // register port address width

	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;  // mmu_control_reg and cache_control_reg bits
	localparam logic [7:0] OFF_ASID   = 8'h04;  // current address space identifier
	localparam logic [7:0] OFF_STATUS = 8'h08;  // sticky events, read only
	localparam logic [7:0] OFF_CLEAR  = 8'h0c;  // write one to clear, write only
	localparam logic [7:0] OFF_ENABLE = 8'h10;  // interrupt enables
	localparam logic [7:0] OFF_FAULT  = 8'h14;  // last faulting virtual address
	localparam logic [7:0] OFF_STATE  = 8'h18;  // decoder state, read only

	// control field positions
	localparam int CTRL_W      = 4;
	localparam int CTRL_XLATE  = 0;        // translation_enable_bit
	localparam int CTRL_CACHE  = 1;        // global cache enable
	localparam int CTRL_WT     = 2;        // write_through_select
	localparam int CTRL_CB     = 3;        // copy_back_select
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [7:0] ASID_RST = 8'h00;

	// event field positions
	localparam int EV_W        = 2;
	localparam int EV_ADDR_ERR = 0;
	localparam int EV_TLB_MISS = 1;
	localparam logic [1:0] EV_RST = 2'h0;

	// top three address bits of each direct or special region
	localparam logic [2:0] TOP_CDIR = 3'h4;  // 0x80000000-0x9fffffff
	localparam logic [2:0] TOP_UDIR = 3'h5;  // 0xa0000000-0xbfffffff
	localparam logic [2:0] TOP_HIGH = 3'h6;  // 0xc0000000-0xdfffffff
	localparam logic [2:0] TOP_CTRL = 3'h7;  // 0xe0000000-0xffffffff

	typedef enum logic [2:0] {
		RG_LOW  = 3'h0,  // user_region / low_privileged_region
		RG_CDIR = 3'h1,  // cached_direct_region
		RG_UDIR = 3'h2,  // uncached_direct_region
		RG_HIGH = 3'h3,  // high_mapped_region
		RG_CTRL = 3'h4   // control_register_region
	} vard_region_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_LOOKUP = 2'b01
	} vard_state_t;
endpackage : vard_pkg

/* File: core/vard_decoder.sv */
// virtual address region decoder: region, privilege, translation and cache decision
// assumes the core, the TLB and the register master all run on clk
`timescale 1ns/1ps

module vard_decoder (
	input  wire logic                             clk,           // 25 MHz clock
	input  wire logic                             sys_rst,       // async reset, high
	input  wire logic [vard_pkg::REG_AW-1:0]      regAddr,       // register byte address
	input  wire logic [31:0]                      regWrData,     // register write data
	input  wire logic                             regWr,         // write strobe
	input  wire logic                             regRd,         // read strobe
	output logic      [31:0]                      regRdData,     // read data, next cycle
	output logic                                  irq,           // level interrupt
	input  wire logic                             cpuReq,        // access request pulse
	input  wire logic [vard_pkg::ADDR_W-1:0]      cpuAddr,       // virtual address
	input  wire logic                             cpuUser,       // 1 = user mode
	input  wire logic                             cpuWrite,      // 1 = write access
	output logic                                  cpuBusy,       // lookup in progress
	output logic                                  accValid,      // decision pulse
	output logic      [vard_pkg::PHYS_W-1:0]      accPhys,       // physical address
	output logic                                  accCache,      // access may use cache
	output logic                                  accWriteThru,  // cached write, write-through
	output logic                                  accCtrlReg,    // control register access
	output logic                                  accWrite,      // access is a write
	output logic                                  accAddrErr,    // address error
	output logic                                  accTlbMiss,    // no TLB entry matched
	output logic                                  tlbReq,        // lookup request pulse
	output logic      [vard_pkg::ADDR_W-1:0]      tlbVaddr,      // address to translate
	output logic      [vard_pkg::ASID_W-1:0]      tlbAsid,       // space identifier
	input  wire logic                             tlbDone,       // lookup answer pulse
	input  wire logic                             tlbHit,        // entry matched
	input  wire logic [vard_pkg::PHYS_W-1:0]      tlbPhys,       // translated address
	input  wire logic                             tlbCacheable   // page cacheable bit
);

	// region from the top address bits; the map is fixed, nothing here is programmable
	//   0x00000000-0x7fffffff user and low privileged, translatable
	//   0x80000000-0x9fffffff cached direct
	//   0xa0000000-0xbfffffff uncached direct
	//   0xc0000000-0xdfffffff high mapped, translatable
	//   0xe0000000-0xffffffff control registers
	function automatic vard_pkg::vard_region_t regionOf(input logic [31:0] va);
		vard_pkg::vard_region_t rg;
		rg = vard_pkg::RG_LOW;
		if (va[31]) begin
			unique case (va[31:29])
				vard_pkg::TOP_CDIR: rg = vard_pkg::RG_CDIR;
				vard_pkg::TOP_UDIR: rg = vard_pkg::RG_UDIR;
				vard_pkg::TOP_HIGH: rg = vard_pkg::RG_HIGH;
				default:            rg = vard_pkg::RG_CTRL;
			endcase
		end
		return rg;
	endfunction : regionOf

	// direct mapping drops the top three bits
	function automatic logic [vard_pkg::PHYS_W-1:0] stripTop(input logic [31:0] va);
		return va[vard_pkg::PHYS_W-1:0];
	endfunction : stripTop

	// regions that the TLB may translate while translation is on
	function automatic logic isMapped(input vard_pkg::vard_region_t rg);
		return (rg == vard_pkg::RG_LOW) || (rg == vard_pkg::RG_HIGH);
	endfunction : isMapped

	// write-through only for a cached write whose policy bit asks for it
	function automatic logic wrThru(input logic cached, input logic wr, input logic policy);
		return cached && wr && policy;
	endfunction : wrThru

	// software-visible registers
	// fault keeps only the latest error or miss; an older one is lost, not queued
	logic [vard_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [vard_pkg::ASID_W-1:0] asid_reg, asid_next;
	logic [vard_pkg::EV_W-1:0]   status_reg, status_next;
	logic [vard_pkg::EV_W-1:0]   enable_reg, enable_next;
	logic [31:0]                 fault_reg, fault_next;
	logic [31:0]                 rdData_reg, rdData_next;
	logic                        irq_reg, irq_next;

	// decode state and registered outputs
	// decision fields hold until the next request is taken, so the core may read them late
	vard_pkg::vard_state_t       state_reg, state_next;
	logic [31:0]                 va_reg, va_next;
	logic                        wr_reg, wr_next;
	logic                        busy_reg, busy_next;
	logic                        valid_reg, valid_next;
	logic [vard_pkg::PHYS_W-1:0] phys_reg, phys_next;
	logic                        cache_reg, cache_next;
	logic                        wt_reg, wt_next;
	logic                        creg_reg, creg_next;
	logic                        aWr_reg, aWr_next;
	logic                        aErr_reg, aErr_next;
	logic                        miss_reg, miss_next;
	logic                        tReq_reg, tReq_next;
	logic [31:0]                 tVa_reg, tVa_next;
	logic [vard_pkg::ASID_W-1:0] tAsid_reg, tAsid_next;
	logic [vard_pkg::EV_W-1:0]   evSet;

	// control bits seen by the decode logic
	logic xlate, cacheOn, wtSel, cbSel;
	assign xlate   = ctrl_reg[vard_pkg::CTRL_XLATE];
	assign cacheOn = ctrl_reg[vard_pkg::CTRL_CACHE];
	assign wtSel   = ctrl_reg[vard_pkg::CTRL_WT];
	assign cbSel   = ctrl_reg[vard_pkg::CTRL_CB];

	// decode next state: classify, check privilege, then translate or map directly
	always_comb begin
		vard_pkg::vard_region_t rg;
		logic                   viol;
		logic                   policy;
		rg          = regionOf(cpuAddr);
		viol        = 1'b0;
		policy      = 1'b0;
		state_next  = state_reg;
		va_next     = va_reg;
		wr_next     = wr_reg;
		valid_next  = 1'b0;
		phys_next   = phys_reg;
		cache_next  = cache_reg;
		wt_next     = wt_reg;
		creg_next   = creg_reg;
		aWr_next    = aWr_reg;
		aErr_next   = aErr_reg;
		miss_next   = miss_reg;
		tReq_next   = 1'b0;
		tVa_next    = tVa_reg;
		tAsid_next  = tAsid_reg;
		fault_next  = fault_reg;
		evSet       = '0;
		unique case (state_reg)
			vard_pkg::ST_IDLE: begin
				if (cpuReq) begin
					// privileged mode passes every region; user mode only the low one
					viol       = cpuUser && (rg != vard_pkg::RG_LOW);
					valid_next = 1'b1;
					aWr_next   = cpuWrite;
					aErr_next  = 1'b0;
					miss_next  = 1'b0;
					creg_next  = 1'b0;
					cache_next = 1'b0;
					wt_next    = 1'b0;
					phys_next  = stripTop(cpuAddr);
					if (viol) begin
						// rejected before any lookup or cache use
						aErr_next  = 1'b1;
						fault_next = cpuAddr;
						evSet[vard_pkg::EV_ADDR_ERR] = 1'b1;
					end else if (xlate && isMapped(rg)) begin
						// answer waits for the TLB
						valid_next = 1'b0;
						tReq_next  = 1'b1;
						tVa_next   = cpuAddr;
						tAsid_next = asid_reg;
						va_next    = cpuAddr;
						wr_next    = cpuWrite;
						state_next = vard_pkg::ST_LOOKUP;
					end else begin
						unique case (rg)
							vard_pkg::RG_LOW, vard_pkg::RG_HIGH: begin
								cache_next = cacheOn;
								policy     = wtSel;
							end
							vard_pkg::RG_CDIR: begin
								cache_next = cacheOn;
								policy     = !cbSel;
							end
							vard_pkg::RG_UDIR: cache_next = 1'b0;
							vard_pkg::RG_CTRL: creg_next = 1'b1;
						endcase
						wt_next = wrThru(cache_next, cpuWrite, policy);
					end
				end
			end
			vard_pkg::ST_LOOKUP: begin
				// a request raised while busy is dropped; the core must wait for cpuBusy low
				if (tlbDone) begin
					valid_next = 1'b1;
					state_next = vard_pkg::ST_IDLE;
					if (tlbHit) begin
						// page bit and global bit must both allow the cache
						phys_next  = tlbPhys;
						cache_next = cacheOn && tlbCacheable;
						wt_next    = wrThru(cache_next, wr_reg, wtSel);
					end else begin
						miss_next  = 1'b1;
						fault_next = va_reg;
						evSet[vard_pkg::EV_TLB_MISS] = 1'b1;
					end
				end
			end
			default: state_next = vard_pkg::ST_IDLE;
		endcase
		busy_next = (state_next == vard_pkg::ST_LOOKUP);
	end

	// decode registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= vard_pkg::ST_IDLE;
			va_reg    <= '0;
			wr_reg    <= 1'b0;
			busy_reg  <= 1'b0;
			valid_reg <= 1'b0;
			phys_reg  <= '0;
			cache_reg <= 1'b0;
			wt_reg    <= 1'b0;
			creg_reg  <= 1'b0;
			aWr_reg   <= 1'b0;
			aErr_reg  <= 1'b0;
			miss_reg  <= 1'b0;
			tReq_reg  <= 1'b0;
			tVa_reg   <= '0;
			tAsid_reg <= '0;
			fault_reg <= '0;
		end else begin
			state_reg <= state_next;
			va_reg    <= va_next;
			wr_reg    <= wr_next;
			busy_reg  <= busy_next;
			valid_reg <= valid_next;
			phys_reg  <= phys_next;
			cache_reg <= cache_next;
			wt_reg    <= wt_next;
			creg_reg  <= creg_next;
			aWr_reg   <= aWr_next;
			aErr_reg  <= aErr_next;
			miss_reg  <= miss_next;
			tReq_reg  <= tReq_next;
			tVa_reg   <= tVa_next;
			tAsid_reg <= tAsid_next;
			fault_reg <= fault_next;
		end
	end

	// register port: writes, clears and read mux; a set beats a clear in the same cycle
	always_comb begin
		ctrl_next   = ctrl_reg;
		asid_next   = asid_reg;
		enable_next = enable_reg;
		status_next = status_reg;
		rdData_next = 32'h0;
		if (regWr) begin
			unique case (regAddr)
				vard_pkg::OFF_CTRL:   ctrl_next = regWrData[vard_pkg::CTRL_W-1:0];
				vard_pkg::OFF_ASID:   asid_next = regWrData[vard_pkg::ASID_W-1:0];
				vard_pkg::OFF_ENABLE: enable_next = regWrData[vard_pkg::EV_W-1:0];
				vard_pkg::OFF_CLEAR:  status_next = status_reg & ~regWrData[vard_pkg::EV_W-1:0];
				default: ;
			endcase
		end
		status_next = status_next | evSet;
		if (regRd) begin
			unique case (regAddr)
				vard_pkg::OFF_CTRL:   rdData_next = {28'h0, ctrl_reg};
				vard_pkg::OFF_ASID:   rdData_next = {24'h0, asid_reg};
				vard_pkg::OFF_STATUS: rdData_next = {30'h0, status_reg};
				vard_pkg::OFF_ENABLE: rdData_next = {30'h0, enable_reg};
				vard_pkg::OFF_FAULT:  rdData_next = fault_reg;
				vard_pkg::OFF_STATE:  rdData_next = {30'h0, state_reg};
				default:              rdData_next = 32'h0;  // unmapped and write-only
			endcase
		end
		// irq follows the stored status so it never glitches on a combinational path
		irq_next = |(status_next & enable_next);
	end

	// register port registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg   <= vard_pkg::CTRL_RST;
			asid_reg   <= vard_pkg::ASID_RST;
			status_reg <= vard_pkg::EV_RST;
			enable_reg <= vard_pkg::EV_RST;
			rdData_reg <= 32'h0;
			irq_reg    <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			asid_reg   <= asid_next;
			status_reg <= status_next;
			enable_reg <= enable_next;
			rdData_reg <= rdData_next;
			irq_reg    <= irq_next;
		end
	end

	// every output straight from a flip-flop, so the core and TLB see no decode glitches
	// register port side
	assign regRdData    = rdData_reg;
	assign irq          = irq_reg;
	// core side
	assign cpuBusy      = busy_reg;
	assign accValid     = valid_reg;
	assign accPhys      = phys_reg;
	assign accCache     = cache_reg;
	assign accWriteThru = wt_reg;
	assign accCtrlReg   = creg_reg;
	assign accWrite     = aWr_reg;
	assign accAddrErr   = aErr_reg;
	assign accTlbMiss   = miss_reg;
	// TLB side
	assign tlbReq       = tReq_reg;
	assign tlbVaddr     = tVa_reg;
	assign tlbAsid      = tAsid_reg;

endmodule : vard_decoder

/* File: sim/vard_decoder_checker.sv */
// checker: decode timing and routing relations at the decoder ports
// assumes it is bound onto every vard_decoder instance
`timescale 1ns/1ps
module vard_decoder_checker (
	input wire logic        clk,        // clock
	input wire logic        sys_rst,    // reset
	input wire logic        cpuReq,     // request
	input wire logic        cpuBusy,    // busy
	input wire logic        cpuUser,    // user mode
	input wire logic [31:0] cpuAddr,    // address
	input wire logic        accValid,   // decision
	input wire logic [28:0] accPhys,    // physical
	input wire logic        accCache,   // cacheable
	input wire logic        accCtrlReg, // control region
	input wire logic        accAddrErr, // error
	input wire logic        accTlbMiss, // miss
	input wire logic        tlbReq,     // lookup
	input wire logic        tlbDone,    // answer
	input wire logic        tlbHit,     // hit
	input wire logic [28:0] tlbPhys     // translated
);
	default clocking dclk @(posedge clk); endclocking
	default disable iff (sys_rst);
	// a request is only taken while idle
	wire logic take = cpuReq && !cpuBusy;
	answer_slot_a: assert property (take |=> accValid ^ tlbReq)
		else $error("request gave neither decision nor lookup");
	user_reject_a: assert property (take && cpuUser && cpuAddr[31] |=> accValid && accAddrErr && !tlbReq)
		else $error("user access outside user region not rejected");
	rights_ok_a: assert property (take && !(cpuUser && cpuAddr[31]) |=> !accAddrErr)
		else $error("allowed access flagged as address error");
	cdir_direct_a: assert property (take && !cpuUser && cpuAddr[31:29] == 3'h4 |=> !tlbReq && accPhys == $past(cpuAddr[28:0]))
		else $error("cached direct access translated");
	udir_bypass_a: assert property (take && !cpuUser && cpuAddr[31:29] == 3'h5 |=> !tlbReq && !accCache && accPhys == $past(cpuAddr[28:0]))
		else $error("uncached direct access not bypassed");
	ctrl_route_a: assert property (take && !cpuUser && cpuAddr[31:29] == 3'h7 |=> accCtrlReg && !accCache && !tlbReq)
		else $error("control region access misrouted");
	lookup_end_a: assert property (tlbDone && cpuBusy |=> accValid && !cpuBusy)
		else $error("lookup answer not turned into decision");
	hit_phys_a: assert property (tlbDone && cpuBusy && tlbHit |=> accPhys == $past(tlbPhys) && !accTlbMiss)
		else $error("translated address not passed on");
	miss_flag_a: assert property (tlbDone && cpuBusy && !tlbHit |=> accTlbMiss && !accCache)
		else $error("miss not reported");
	busy_start_a: assert property ($rose(cpuBusy) |-> tlbReq)
		else $error("busy without lookup");
endmodule : vard_decoder_checker

bind vard_decoder vard_decoder_checker chkI (.clk(clk), .sys_rst(sys_rst), .cpuReq(cpuReq),
	.cpuBusy(cpuBusy), .cpuUser(cpuUser), .cpuAddr(cpuAddr), .accValid(accValid),
	.accPhys(accPhys), .accCache(accCache), .accCtrlReg(accCtrlReg), .accAddrErr(accAddrErr),
	.accTlbMiss(accTlbMiss), .tlbReq(tlbReq), .tlbDone(tlbDone), .tlbHit(tlbHit), .tlbPhys(tlbPhys));

/* File: sim/vard_tlb_model.sv */
// partner model: TLB answering lookups after a chosen wait
// assumes the bench sets the wait, hit, cacheable and address choices
`timescale 1ns/1ps
module vard_tlb_model (
	input wire logic        clk,         // clock
	input wire logic        sys_rst,     // reset
	input wire logic        tlbReq,      // lookup request
	input wire logic [1:0]  waitSel,     // extra wait cycles
	input wire logic        hitSel,      // answer hit
	input wire logic        cacheSel,    // page cacheable choice
	input wire logic [28:0] physSel,     // mapped address
	output logic            tlbDone,     // answer pulse
	output logic            tlbHit,      // hit
	output logic [28:0]     tlbPhys,     // translated
	output logic            tlbCacheable // page cacheable
);
	// physical area of the control registers; a plain default
	localparam logic [2:0] CTRL_AREA = 3'h1;
	int cnt;
	// between answers the result lines toggle so a stale sample shows up
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= -1;
			tlbDone <= 1'h0;
			tlbHit <= 1'h0;
			tlbPhys <= 29'h0;
			tlbCacheable <= 1'h0;
		end else begin
			tlbDone <= 1'h0;
			tlbHit <= ~tlbHit;
			tlbPhys <= ~tlbPhys;
			tlbCacheable <= ~tlbCacheable;
			if (tlbReq) cnt <= waitSel;
			else if (cnt > 0) cnt <= cnt - 1;
			else if (cnt == 0) begin
				cnt <= -1;
				tlbDone <= 1'h1;
				tlbHit <= hitSel;
				tlbPhys <= physSel;
				tlbCacheable <= cacheSel && physSel[28:26] != CTRL_AREA;
			end
		end
	end
endmodule : vard_tlb_model

/* File: sim/vard_decoder_tb.sv */
// bench: random decodes compared with a reference model
// assumes the TLB model answers every lookup within a few cycles
`timescale 1ns/1ps
module vard_decoder_tb;
	logic        clk = 1'h0, sys_rst = 1'h1, regWr = 1'h0, regRd = 1'h0, cpuReq = 1'h0;
	logic        cpuUser = 1'h0, cpuWrite = 1'h0, hitSel = 1'h0, cacheSel = 1'h0;
	logic        u, w, err, mp, xl, miss, ca, irq, cpuBusy, accValid, accCache;
	logic        accWriteThru, accCtrlReg, accWrite, accAddrErr, accTlbMiss;
	logic        tlbReq, tlbDone, tlbHit, tlbCacheable;
	logic [1:0]  waitSel = 2'h0, en;
	logic [2:0]  top;
	logic [3:0]  ctrl;
	logic [7:0]  regAddr = 8'h00, asid, tlbAsid;
	logic [28:0] physSel = 29'h0, accPhys, tlbPhys;
	logic [31:0] regWrData = 32'h0, cpuAddr = 32'h0, regRdData, tlbVaddr, a, rd;
	logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
	logic [31:0] flt = 32'h0;
	int          mismatches = 0, checkCount = 0, reqCnt = 0, r0;
	vard_decoder DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq), .cpuReq(cpuReq),
		.cpuAddr(cpuAddr), .cpuUser(cpuUser), .cpuWrite(cpuWrite), .cpuBusy(cpuBusy),
		.accValid(accValid), .accPhys(accPhys), .accCache(accCache),
		.accWriteThru(accWriteThru), .accCtrlReg(accCtrlReg), .accWrite(accWrite),
		.accAddrErr(accAddrErr), .accTlbMiss(accTlbMiss), .tlbReq(tlbReq),
		.tlbVaddr(tlbVaddr), .tlbAsid(tlbAsid), .tlbDone(tlbDone), .tlbHit(tlbHit),
		.tlbPhys(tlbPhys), .tlbCacheable(tlbCacheable));
	vard_tlb_model tlbM (.clk(clk), .sys_rst(sys_rst), .tlbReq(tlbReq), .waitSel(waitSel),
		.hitSel(hitSel), .cacheSel(cacheSel), .physSel(physSel), .tlbDone(tlbDone),
		.tlbHit(tlbHit), .tlbPhys(tlbPhys), .tlbCacheable(tlbCacheable));
	// 25 MHz clock
	initial forever #20 clk = ~clk;
	// lookups counted mid-cycle, apart from the edge updates
	always @(negedge clk) if (tlbReq === 1'h1) reqCnt++;
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checkCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic testDone;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : testDone
	task automatic regW(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		regAddr <= ad;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge clk);
		regWr <= 1'h0;
	endtask : regW
	// read data stands only in the cycle after the strobe edge
	task automatic regR(input logic [7:0] ad, output logic [31:0] d);
		@(posedge clk);
		regAddr <= ad;
		regRd <= 1'h1;
		@(posedge clk);
		regRd <= 1'h0;
		@(negedge clk);
		d = regRdData;
	endtask : regR
	// returns in the decision cycle, a lookup may stretch it
	task automatic access(input logic [31:0] ad, input logic us, wr);
		int n;
		@(posedge clk);
		cpuReq <= 1'h1;
		cpuAddr <= ad;
		cpuUser <= us;
		cpuWrite <= wr;
		@(posedge clk);
		cpuReq <= 1'h0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (accValid !== 1'h1 && n < 20);
		if (accValid !== 1'h1) begin
			mismatches++;
			testDone();
		end
	endtask : access
	initial begin
		r0 = $urandom(59025);
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		regW(8'h08, 32'h3);
		for (int k = 0; k < 8; k++) begin
			regR(offs[k], rd);
			chk("reset read", rd, 32'h0);
		end
		for (int i = 0; i < 96; i++) begin
			top = i[2:0];
			a = {top, 29'($urandom())};
			{ctrl, asid, en, u, w} = 16'($urandom());
			regW(8'h00, {28'h0, ctrl});
			regW(8'h04, {24'h0, asid});
			regW(8'h10, {30'h0, en});
			{waitSel, hitSel, cacheSel} <= 4'($urandom());
			physSel <= 29'($urandom());
			r0 = reqCnt;
			access(a, u, w);
			err = u & a[31];
			mp = top < 3'h4 || top == 3'h6;
			xl = mp & !err & ctrl[0];
			miss = xl & !hitSel;
			ca = !(err | miss) & ctrl[1];
			ca = ca & (top == 3'h4 | mp & (!ctrl[0] | cacheSel & physSel[28:26] != 3'h1));
			chk("phys", accPhys, xl && hitSel ? physSel : a[28:0]);
			chk("cache", accCache, ca);
			chk("wthru", accWriteThru, ca & w & (top == 3'h4 ? !ctrl[3] : ctrl[2]));
			chk("adderr", accAddrErr, err);
			chk("miss", accTlbMiss, miss);
			chk("ctlreg", accCtrlReg, !err & top == 3'h7);
			chk("write", accWrite, w);
			chk("irq", irq, |({miss, err} & en));
			if (xl) chk("vaddr", tlbVaddr, a);
			if (xl) chk("asid", tlbAsid, asid);
			regR(8'h08, rd);
			chk("status", rd, {30'h0, miss, err});
			chk("lookups", reqCnt - r0, xl);
			if (err | miss) flt = a;
			regR(8'h14, rd);
			chk("fault", rd, flt);
			regR(8'h00, rd);
			chk("ctrl", rd, {28'h0, ctrl});
			regW(8'h0c, 32'h3);
			regR(8'h08, rd);
			chk("cleared", rd, 32'h0);
			chk("irq off", irq, 32'h0);
		end
		// state register read while a lookup is pending
		regW(8'h00, 32'h1);
		fork
			access(32'h00001000, 1'h0, 1'h0);
			begin
				@(posedge clk);
				regR(8'h18, rd);
			end
		join
		chk("state", rd, 32'h1);
		testDone();
	end
endmodule : vard_decoder_tb
